//--- core/buck_regs_pkg.sv
package buck_regs_pkg;

   // ----------------------------------------------------------------
   // register offsets on the serial control port
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_BUCK2_SLEEP_VOLTAGE = 8'h37;
   localparam logic [7:0] ADDR_BUCK2_MODE_SELECT = 8'h38;
   localparam logic [7:0] ADDR_BUCK2_CONFIG = 8'h39;
   localparam logic [7:0] ADDR_BUCK3_RUN_VOLTAGE = 8'h3c;
   localparam logic [7:0] ADDR_BUCK3_STANDBY_VOLTAGE = 8'h3d;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int OFF_EVENT_BIT = 5;
   localparam int SWITCH_MODE_LSB = 0;
   localparam int SWITCH_MODE_MSB = 3;
   localparam int RAMP_SPEED_BIT = 6;
   localparam int PHASE_LSB = 4;
   localparam int PHASE_MSB = 5;
   localparam int FREQ_LSB = 2;
   localparam int FREQ_MSB = 3;
   localparam int ILIM_BIT = 0;
   localparam int HIGH_RANGE_BIT = 5;
   localparam int LEVEL_LSB = 0;
   localparam int LEVEL_MSB = 4;
   localparam int LEVEL_W = LEVEL_MSB - LEVEL_LSB + 1;

   // ----------------------------------------------------------------
   // implemented bits, bits loaded from otp, fixed reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] MODE_SELECT_MASK = 8'h2f;
   localparam logic [7:0] CONFIG_MASK = 8'h7d;
   localparam logic [7:0] SLEEP_VOLTAGE_MASK = 8'h3f;
   localparam logic [7:0] LEVEL_MASK = 8'h1f;
   localparam logic [7:0] MODE_SELECT_OTP_MASK = 8'h0f;
   localparam logic [7:0] CONFIG_OTP_MASK = 8'h4d;
   localparam logic [7:0] SLEEP_VOLTAGE_OTP_MASK = 8'h3f;
   localparam logic [7:0] LEVEL_OTP_MASK = 8'h1f;
   localparam logic [7:0] MODE_SELECT_FIXED_RESET = 8'h00;
   localparam logic [7:0] CONFIG_FIXED_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 20;
   localparam int RAMP_FAST_STEP_NS = 2000;
   localparam int RAMP_SLOW_STEP_NS = 4000;
   localparam int RAMP_CNT_W = 8;
   localparam logic [RAMP_CNT_W-1:0] RAMP_FAST_CYCLES = RAMP_CNT_W'(RAMP_FAST_STEP_NS / CLK_PERIOD_NS);
   localparam logic [RAMP_CNT_W-1:0] RAMP_SLOW_CYCLES = RAMP_CNT_W'(RAMP_SLOW_STEP_NS / CLK_PERIOD_NS);

   // ----------------------------------------------------------------
   // serial control port
   // ----------------------------------------------------------------
   localparam logic [6:0] DEVICE_ADDR_DEFAULT = 7'h08; // arbitrary value
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_ADDR = 4'h1,
      ST_ADDR_ACK = 4'h2,
      ST_PTR = 4'h3,
      ST_PTR_ACK = 4'h4,
      ST_WDATA = 4'h5,
      ST_WDATA_ACK = 4'h6,
      ST_RDATA = 4'h7,
      ST_RDATA_ACK = 4'h8
   } link_state_e;

endpackage : buck_regs_pkg

//--- core/buck2_ramp_timer.sv
`timescale 1ns/1ps
`default_nettype none

module buck2_ramp_timer #(
   parameter int CODE_W = buck_regs_pkg::LEVEL_W
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic [CODE_W-1:0] target_code,
   input wire logic ramp_slow,
   output logic [CODE_W-1:0] level,
   output logic busy
);
   import buck_regs_pkg::*;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic primed;
      logic [CODE_W-1:0] level;
      logic [RAMP_CNT_W-1:0] cnt;
      logic busy;
   } ramp_s;

   ramp_s s;
   ramp_s next_s;
   logic [RAMP_CNT_W-1:0] step_cycles;

   if (CODE_W < 1 || CODE_W > 8) begin : g_bad_width
      $error("buck2_ramp_timer: CODE_W must be 1 to 8");
   end

   // step interval follows the speed bit live, so a change applies to the step already in progress
   assign step_cycles = ramp_slow ? RAMP_SLOW_CYCLES : RAMP_FAST_CYCLES;

   // one code step per interval toward the target; first cycle snaps, no power-up ramp
   always_comb begin
      next_s = s;
      if (!s.primed) begin
         next_s.primed = 1'b1;
         next_s.level = target_code;
         next_s.cnt = '0;
         next_s.busy = 1'b0;
      end else if (s.level != target_code) begin
         next_s.busy = 1'b1;
         if (s.cnt >= step_cycles - 1'b1) begin
            next_s.cnt = '0;
            next_s.level = (s.level < target_code) ? s.level + 1'b1 : s.level - 1'b1;
         end else begin
            next_s.cnt = s.cnt + 1'b1;
         end
      end else begin
         next_s.busy = 1'b0;
         next_s.cnt = '0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign level = s.level;
   assign busy = s.busy;

endmodule : buck2_ramp_timer

`default_nettype wire

//--- core/buck_regulator_control_registers.sv
`timescale 1ns/1ps
`default_nettype none

module buck_regulator_control_registers #(
   parameter logic [6:0] DEVICE_ADDR = buck_regs_pkg::DEVICE_ADDR_DEFAULT
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic [7:0] otp_buck2_mode,
   input wire logic [7:0] otp_buck2_config,
   input wire logic [7:0] otp_buck2_sleep,
   input wire logic [7:0] otp_buck3_run,
   input wire logic [7:0] otp_buck3_standby,
   input wire logic [buck_regs_pkg::LEVEL_W-1:0] buck2_target_code,
   output logic buck2_off_event_behavior,
   output logic [3:0] buck2_switch_mode_code,
   output logic buck2_ramp_speed_sel,
   output logic [1:0] buck2_clock_phase_sel,
   output logic [1:0] buck2_frequency_sel,
   output logic buck2_current_limit_sel,
   output logic buck2_high_range,
   output logic [buck_regs_pkg::LEVEL_W-1:0] buck2_sleep_level,
   output logic [buck_regs_pkg::LEVEL_W-1:0] buck3_run_level,
   output logic [buck_regs_pkg::LEVEL_W-1:0] buck3_standby_level,
   output logic [buck_regs_pkg::LEVEL_W-1:0] buck2_ramped_code,
   output logic voltage_ramping,
   output logic link_active
);
   import buck_regs_pkg::*;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic scl_meta;
      logic scl_sync;
      logic scl_last;
      logic sda_meta;
      logic sda_sync;
      logic sda_last;
      link_state_e st;
      logic [3:0] cnt;
      logic [7:0] shift;
      logic read_dir;
      logic [7:0] ptr;
      logic [7:0] rd_byte;
      logic sda_drive;
      logic sda_level;
      logic otp_loaded;
      logic busy;
      logic [7:0] mode_select;
      logic [7:0] config_bits;
      logic [7:0] sleep_voltage;
      logic [7:0] run_voltage;
      logic [7:0] standby_voltage;
   } regs_s;

   regs_s s;
   regs_s next_s;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;
   logic addr_match;

   if (DEVICE_ADDR > 7'h77 || DEVICE_ADDR < 7'h08) begin : g_bad_addr
      $error("buck_regulator_control_registers: DEVICE_ADDR is a reserved bus address");
   end

   // ----------------------------------------------------------------
   // register read and write decode
   // ----------------------------------------------------------------
   // unmapped offsets read zero; reserved bits are never stored, so they read zero too
   function automatic logic [7:0] reg_read(input regs_s r, input logic [7:0] a);
      logic [7:0] d;
      d = UNMAPPED_READ_VALUE;
      unique case (a)
         ADDR_BUCK2_SLEEP_VOLTAGE: d = r.sleep_voltage;
         ADDR_BUCK2_MODE_SELECT: d = r.mode_select;
         ADDR_BUCK2_CONFIG: d = r.config_bits;
         ADDR_BUCK3_RUN_VOLTAGE: d = r.run_voltage;
         ADDR_BUCK3_STANDBY_VOLTAGE: d = r.standby_voltage;
         default: d = UNMAPPED_READ_VALUE;
      endcase
      return d;
   endfunction : reg_read

   // writes are masked to implemented bits; unmapped offsets drop the byte
   function automatic regs_s reg_write(input regs_s r, input logic [7:0] a, input logic [7:0] d);
      regs_s w;
      w = r;
      unique case (a)
         ADDR_BUCK2_SLEEP_VOLTAGE: w.sleep_voltage = d & SLEEP_VOLTAGE_MASK;
         ADDR_BUCK2_MODE_SELECT: w.mode_select = d & MODE_SELECT_MASK;
         ADDR_BUCK2_CONFIG: w.config_bits = d & CONFIG_MASK;
         ADDR_BUCK3_RUN_VOLTAGE: w.run_voltage = d & LEVEL_MASK;
         ADDR_BUCK3_STANDBY_VOLTAGE: w.standby_voltage = d & LEVEL_MASK;
         default: w = r;
      endcase
      return w;
   endfunction : reg_write

   // ----------------------------------------------------------------
   // bus condition detection
   // ----------------------------------------------------------------
   // edges are taken between the second sync stage and its delayed copy only
   assign scl_rise = s.scl_sync & ~s.scl_last;
   assign scl_fall = ~s.scl_sync & s.scl_last;
   assign start_seen = s.scl_sync & s.scl_last & ~s.sda_sync & s.sda_last;
   assign stop_seen = s.scl_sync & s.scl_last & s.sda_sync & ~s.sda_last;
   assign addr_match = (s.shift[7:1] == DEVICE_ADDR);

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      next_s = s;
      // two-stage synchronisers on the bus pins
      next_s.scl_meta = scl_in;
      next_s.scl_sync = s.scl_meta;
      next_s.scl_last = s.scl_sync;
      next_s.sda_meta = sda_in;
      next_s.sda_sync = s.sda_meta;
      next_s.sda_last = s.sda_sync;
      // open drain: the data line is only ever pulled low
      next_s.sda_level = 1'b0;

      // first cycle after reset copies the otp image into the loadable fields
      if (!s.otp_loaded) begin
         next_s.otp_loaded = 1'b1;
         next_s.mode_select = MODE_SELECT_FIXED_RESET | (otp_buck2_mode & MODE_SELECT_OTP_MASK);
         next_s.config_bits = CONFIG_FIXED_RESET | (otp_buck2_config & CONFIG_OTP_MASK);
         next_s.sleep_voltage = otp_buck2_sleep & SLEEP_VOLTAGE_OTP_MASK;
         next_s.run_voltage = otp_buck3_run & LEVEL_OTP_MASK;
         next_s.standby_voltage = otp_buck3_standby & LEVEL_OTP_MASK;
      end

      // no lock and no state gating: any mode of the regulator accepts access
      if (start_seen) begin
         next_s.st = ST_ADDR;
         next_s.cnt = '0;
         next_s.sda_drive = 1'b0;
         next_s.busy = 1'b1;
      end else if (stop_seen) begin
         next_s.st = ST_IDLE;
         next_s.sda_drive = 1'b0;
         next_s.busy = 1'b0;
      end else begin
         unique case (s.st)
            ST_IDLE: begin
               next_s.sda_drive = 1'b0;
               next_s.busy = 1'b0;
            end
            // address byte, msb first, then the direction bit
            ST_ADDR: begin
               if (scl_rise) begin
                  next_s.shift = {s.shift[6:0], s.sda_sync};
                  next_s.cnt = s.cnt + 1'b1;
               end else if (scl_fall && s.cnt == BITS_PER_BYTE) begin
                  if (addr_match) begin
                     next_s.st = ST_ADDR_ACK;
                     next_s.read_dir = s.shift[0];
                     next_s.sda_drive = 1'b1;
                  end else begin
                     // another device is addressed: stay off the bus until the next start
                     next_s.st = ST_IDLE;
                  end
               end
            end
            ST_ADDR_ACK: begin
               if (scl_fall) begin
                  next_s.cnt = '0;
                  if (s.read_dir) begin
                     // reads continue from the pointer left by the last access
                     next_s.rd_byte = reg_read(s, s.ptr);
                     next_s.sda_drive = ~next_s.rd_byte[7];
                     next_s.st = ST_RDATA;
                  end else begin
                     next_s.sda_drive = 1'b0;
                     next_s.st = ST_PTR;
                  end
               end
            end
            // register pointer byte of a write transfer
            ST_PTR: begin
               if (scl_rise) begin
                  next_s.shift = {s.shift[6:0], s.sda_sync};
                  next_s.cnt = s.cnt + 1'b1;
               end else if (scl_fall && s.cnt == BITS_PER_BYTE) begin
                  next_s.ptr = s.shift;
                  next_s.sda_drive = 1'b1;
                  next_s.st = ST_PTR_ACK;
               end
            end
            ST_PTR_ACK: begin
               if (scl_fall) begin
                  next_s.sda_drive = 1'b0;
                  next_s.cnt = '0;
                  next_s.st = ST_WDATA;
               end
            end
            // data bytes: each one lands on the pointer, which then advances
            ST_WDATA: begin
               if (scl_rise) begin
                  next_s.shift = {s.shift[6:0], s.sda_sync};
                  next_s.cnt = s.cnt + 1'b1;
               end else if (scl_fall && s.cnt == BITS_PER_BYTE) begin
                  next_s = reg_write(next_s, s.ptr, s.shift);
                  next_s.ptr = s.ptr + 8'h01;
                  next_s.sda_drive = 1'b1;
                  next_s.st = ST_WDATA_ACK;
               end
            end
            ST_WDATA_ACK: begin
               if (scl_fall) begin
                  next_s.sda_drive = 1'b0;
                  next_s.cnt = '0;
                  next_s.st = ST_WDATA;
               end
            end
            // read data: next bit goes out on each falling clock edge
            ST_RDATA: begin
               if (scl_rise) begin
                  next_s.cnt = s.cnt + 1'b1;
               end else if (scl_fall) begin
                  if (s.cnt == BITS_PER_BYTE) begin
                     next_s.sda_drive = 1'b0;
                     next_s.st = ST_RDATA_ACK;
                  end else begin
                     next_s.rd_byte = {s.rd_byte[6:0], 1'b0};
                     next_s.sda_drive = ~s.rd_byte[6];
                  end
               end
            end
            // the host acknowledges; a high level ends the read
            ST_RDATA_ACK: begin
               if (scl_rise) begin
                  next_s.shift = {s.shift[7:1], s.sda_sync};
               end else if (scl_fall) begin
                  if (s.shift[0]) begin
                     next_s.st = ST_IDLE;
                     next_s.busy = 1'b0;
                  end else begin
                     next_s.ptr = s.ptr + 8'h01;
                     next_s.rd_byte = reg_read(s, s.ptr + 8'h01);
                     next_s.sda_drive = ~next_s.rd_byte[7];
                     next_s.cnt = '0;
                     next_s.st = ST_RDATA;
                  end
               end
            end
            default: begin
               next_s.st = ST_IDLE;
               next_s.sda_drive = 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   // all-zero reset; the otp copy follows on the first edge after release
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // ----------------------------------------------------------------
   // voltage ramp pacing for the second buck
   // ----------------------------------------------------------------
   buck2_ramp_timer #(
      .CODE_W(LEVEL_W)
   ) u_ramp (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .target_code(buck2_target_code),
      .ramp_slow(s.config_bits[RAMP_SPEED_BIT]),
      .level(buck2_ramped_code),
      .busy(voltage_ramping)
   );

   // ----------------------------------------------------------------
   // outputs, all straight from the state register
   // ----------------------------------------------------------------
   assign sda_out = s.sda_level;
   assign sda_oe = s.sda_drive;
   assign link_active = s.busy;
   assign buck2_off_event_behavior = s.mode_select[OFF_EVENT_BIT];
   assign buck2_switch_mode_code = s.mode_select[SWITCH_MODE_MSB:SWITCH_MODE_LSB];
   assign buck2_ramp_speed_sel = s.config_bits[RAMP_SPEED_BIT];
   assign buck2_clock_phase_sel = s.config_bits[PHASE_MSB:PHASE_LSB];
   assign buck2_frequency_sel = s.config_bits[FREQ_MSB:FREQ_LSB];
   assign buck2_current_limit_sel = s.config_bits[ILIM_BIT];
   assign buck2_high_range = s.sleep_voltage[HIGH_RANGE_BIT];
   assign buck2_sleep_level = s.sleep_voltage[LEVEL_MSB:LEVEL_LSB];
   assign buck3_run_level = s.run_voltage[LEVEL_MSB:LEVEL_LSB];
   assign buck3_standby_level = s.standby_voltage[LEVEL_MSB:LEVEL_LSB];

endmodule : buck_regulator_control_registers

`default_nettype wire

//--- dv/buck_regs_host.sv
`timescale 1ns/1ps
`default_nettype none
// serial bus master standing in for the host processor
module buck_regs_host (
   input wire logic sys_clk,
   input wire logic sda_line,
   output logic scl,
   output logic sda_low,
   output logic rd_valid,
   output logic [7:0] rd_data
);
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
      rd_valid = 1'b0;
      rd_data = 8'h00;
   end
   // one quarter bit; scl low and high 12 cycles each, the device needs 10
   task automatic step(input logic c, input logic d);
      scl <= c;
      sda_low <= d;
      repeat (6) @(posedge sys_clk);
   endtask : step
   // data moves only while scl is low
   task automatic bit_io(input logic b, output logic r);
      step(scl, !b);
      step(1'b1, !b);
      r = sda_line;
      step(1'b1, !b);
      step(1'b0, !b);
   endtask : bit_io
   // start or repeated start, any time
   task automatic start();
      step(scl, 1'b0);
      step(1'b1, 1'b0);
      step(1'b1, 1'b1);
      step(1'b0, 1'b1);
   endtask : start
   task automatic stop();
      step(scl, 1'b1);
      step(1'b1, 1'b1);
      step(1'b1, 1'b0);
   endtask : stop
   // eight bits msb first, then the ninth bit
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(tx[i], r);
         rx[i] = r;
      end
      bit_io(1'b1, r);
      ack = !r;
   endtask : xfer
   task automatic write_reg(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d, output logic ack);
      logic [7:0] rx;
      logic a0, a1, a2;
      start();
      xfer({dev, 1'b0}, rx, a0);
      xfer(a, rx, a1);
      xfer(d, rx, a2);
      stop();
      ack = a0 & a1 & a2;
   endtask : write_reg
   // pointer write, repeated start, one byte read and refused with nack
   task automatic read_reg(input logic [6:0] dev, input logic [7:0] a);
      logic [7:0] rx;
      logic ack;
      start();
      xfer({dev, 1'b0}, rx, ack);
      xfer(a, rx, ack);
      start();
      xfer({dev, 1'b1}, rx, ack);
      xfer(8'hff, rx, ack);
      stop();
      rd_data <= rx;
      rd_valid <= 1'b1;
      @(posedge sys_clk);
      rd_valid <= 1'b0;
   endtask : read_reg
endmodule : buck_regs_host
`default_nettype wire

//--- dv/buck_regs_props.sv
`timescale 1ns/1ps
`default_nettype none
module buck_regs_props
   import buck_regs_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic [7:0] otp_buck2_mode,
   input wire logic [7:0] otp_buck2_config,
   input wire logic [7:0] otp_buck2_sleep,
   input wire logic [7:0] otp_buck3_run,
   input wire logic [7:0] otp_buck3_standby,
   input wire logic [LEVEL_W-1:0] buck2_target_code,
   input wire logic buck2_off_event_behavior,
   input wire logic [3:0] buck2_switch_mode_code,
   input wire logic buck2_ramp_speed_sel,
   input wire logic [1:0] buck2_clock_phase_sel,
   input wire logic [1:0] buck2_frequency_sel,
   input wire logic buck2_current_limit_sel,
   input wire logic buck2_high_range,
   input wire logic [LEVEL_W-1:0] buck2_sleep_level,
   input wire logic [LEVEL_W-1:0] buck3_run_level,
   input wire logic [LEVEL_W-1:0] buck3_standby_level,
   input wire logic [LEVEL_W-1:0] buck2_ramped_code,
   input wire logic voltage_ramping,
   input wire logic link_active
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   logic [26:0] fields;
   logic [LEVEL_W-1:0] prev_code;
   logic [7:0] gap;
   logic [1:0] up;
   assign fields = {buck2_off_event_behavior, buck2_switch_mode_code, buck2_ramp_speed_sel, buck2_clock_phase_sel,
      buck2_frequency_sel, buck2_current_limit_sel, buck2_high_range, buck2_sleep_level, buck3_run_level,
      buck3_standby_level};
   // cycles since the paced code last moved, saturating
   always_ff @(posedge sys_clk) begin
      up <= {up[0], rst_b};
      prev_code <= buck2_ramped_code;
      gap <= (!rst_b || buck2_ramped_code != prev_code) ? 8'h00 : ((gap == 8'hff) ? gap : gap + 8'h01);
   end
   // --------------------------------
   // properties
   // --------------------------------
   property p_drive_low_only;
      sda_oe |-> sda_out == 1'b0;
   endproperty
   a_drive_low_only: assert property (p_drive_low_only) else $error("data line driven high");
   property p_quiet_when_idle;
      !link_active && !$past(link_active) |-> !sda_oe;
   endproperty
   a_quiet_when_idle: assert property (p_quiet_when_idle) else $error("data line pulled outside a frame");
   property p_hold_when_idle;
      &up && !link_active && !$past(link_active) |-> $stable(fields);
   endproperty
   a_hold_when_idle: assert property (p_hold_when_idle) else $error("field moved without bus write");
   property p_mode_load;
      $rose(rst_b) |=> buck2_switch_mode_code == otp_buck2_mode[3:0] && !buck2_off_event_behavior;
   endproperty
   a_mode_load: assert property (p_mode_load) else $error("mode fields not loaded");
   property p_config_load;
      $rose(rst_b) |=> buck2_ramp_speed_sel == otp_buck2_config[6] && buck2_clock_phase_sel == 2'h0
         && buck2_frequency_sel == otp_buck2_config[3:2] && buck2_current_limit_sel == otp_buck2_config[0];
   endproperty
   a_config_load: assert property (p_config_load) else $error("config fields not loaded");
   property p_level_load;
      $rose(rst_b) |=> {buck2_high_range, buck2_sleep_level} == otp_buck2_sleep[5:0]
         && buck3_run_level == otp_buck3_run[4:0] && buck3_standby_level == otp_buck3_standby[4:0];
   endproperty
   a_level_load: assert property (p_level_load) else $error("level fields not loaded");
   property p_ramp_flag;
      &up |-> voltage_ramping == ($past(buck2_ramped_code) != $past(buck2_target_code));
   endproperty
   a_ramp_flag: assert property (p_ramp_flag) else $error("ramping flag wrong");
   property p_ramp_pace;
      &up && buck2_ramped_code != prev_code |-> gap >= (buck2_ramp_speed_sel ? 8'hc7 : 8'h63)
         && (buck2_ramped_code - prev_code == 5'h01 || buck2_ramped_code - prev_code == 5'h1f);
   endproperty
   a_ramp_pace: assert property (p_ramp_pace) else $error("ramp step too fast or too big");
   c_ack: cover property ($rose(sda_oe));
   c_frame_end: cover property ($fell(link_active));
   c_ramp: cover property ($rose(voltage_ramping));
endmodule : buck_regs_props
bind buck_regulator_control_registers buck_regs_props u_props (.sys_clk, .rst_b, .sda_out, .sda_oe, .otp_buck2_mode,
   .otp_buck2_config, .otp_buck2_sleep, .otp_buck3_run, .otp_buck3_standby, .buck2_target_code,
   .buck2_off_event_behavior, .buck2_switch_mode_code, .buck2_ramp_speed_sel, .buck2_clock_phase_sel,
   .buck2_frequency_sel, .buck2_current_limit_sel, .buck2_high_range, .buck2_sleep_level, .buck3_run_level,
   .buck3_standby_level, .buck2_ramped_code, .voltage_ramping, .link_active);
`default_nettype wire

//--- dv/test_buck_regulator_control_registers.sv
`timescale 1ns/1ps
`default_nettype none
module test_buck_regulator_control_registers;
   import buck_regs_pkg::*;
   localparam logic [7:0] ADDRS [5] = '{ADDR_BUCK2_MODE_SELECT, ADDR_BUCK2_CONFIG, ADDR_BUCK2_SLEEP_VOLTAGE,
      ADDR_BUCK3_RUN_VOLTAGE, ADDR_BUCK3_STANDBY_VOLTAGE};
   localparam logic [7:0] MASKS [5] = '{MODE_SELECT_MASK, CONFIG_MASK, SLEEP_VOLTAGE_MASK, LEVEL_MASK, LEVEL_MASK};
   localparam logic [7:0] OTPM [5] = '{MODE_SELECT_OTP_MASK, CONFIG_OTP_MASK, SLEEP_VOLTAGE_OTP_MASK, LEVEL_OTP_MASK,
      LEVEL_OTP_MASK};
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] otp [5];
   logic [4:0] target = 5'h00;
   logic scl, sda_low, rd_valid, sda_line, sda_out, sda_oe, ack, off_ev, slow, ilim, high_r, ramping;
   logic [7:0] rd_data;
   logic [4:0] lvl_s, lvl_r, lvl_y, ramped;
   logic [3:0] mode_code;
   logic [1:0] phase, freq;
   logic [7:0] exp_q [$];
   int errors = 0;
   int n_checks = 0;
   int cycles = 0;
   always #10 sys_clk = ~sys_clk;
   // open-drain data line with pull-up
   assign sda_line = !(sda_low || (sda_oe && !sda_out));
   buck_regulator_control_registers dut (.sys_clk, .rst_b, .scl_in(scl), .sda_in(sda_line),
      .sda_out, .sda_oe, .otp_buck2_mode(otp[0]), .otp_buck2_config(otp[1]),
      .otp_buck2_sleep(otp[2]), .otp_buck3_run(otp[3]), .otp_buck3_standby(otp[4]), .buck2_target_code(target),
      .buck2_off_event_behavior(off_ev), .buck2_switch_mode_code(mode_code), .buck2_ramp_speed_sel(slow),
      .buck2_clock_phase_sel(phase), .buck2_frequency_sel(freq), .buck2_current_limit_sel(ilim),
      .buck2_high_range(high_r), .buck2_sleep_level(lvl_s), .buck3_run_level(lvl_r), .buck3_standby_level(lvl_y),
      .buck2_ramped_code(ramped), .voltage_ramping(ramping), .link_active());
   buck_regs_host host (.sys_clk, .sda_line, .scl, .sda_low, .rd_valid, .rd_data);
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic summarize();
      if (errors == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : summarize
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      host.read_reg(DEVICE_ADDR_DEFAULT, a);
   endtask : rd
   // each read against the oldest note; the ceiling cuts a hang
   always @(posedge sys_clk) begin
      cycles++;
      if (rd_valid === 1'b1) begin
         check(rd_data, exp_q.pop_front());
      end
      if (cycles == 60000) begin
         errors++;
         $display("Error at %0t: timeout", $time);
         summarize();
      end
   end
   initial begin
      logic [7:0] w [5];
      logic seen;
      int n, lo;
      w[0] = 8'($urandom(78527));
      foreach (otp[i]) otp[i] = 8'($urandom);
      repeat (12) @(posedge sys_clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge sys_clk);
      for (int i = 0; i < 5; i++) rd(ADDRS[i], otp[i] & OTPM[i]);
      // all ones, all zeros, then random: reserved bits must stay zero
      for (int k = 0; k < 3; k++) begin
         for (int i = 0; i < 5; i++) begin
            w[i] = (k == 0) ? 8'hff : ((k == 1) ? 8'h00 : 8'($urandom));
            host.write_reg(DEVICE_ADDR_DEFAULT, ADDRS[i], w[i], ack);
            check({7'h00, ack}, 8'h01);
            rd(ADDRS[i], w[i] & MASKS[i]);
         end
         check({2'h0, off_ev, 1'b0, mode_code}, w[0] & MODE_SELECT_MASK);
         check({1'b0, slow, phase, freq, 1'b0, ilim}, w[1] & CONFIG_MASK);
         check({2'h0, high_r, lvl_s}, w[2] & SLEEP_VOLTAGE_MASK);
         check({3'h0, lvl_r}, w[3] & LEVEL_MASK);
         check({3'h0, lvl_y}, w[4] & LEVEL_MASK);
      end
      // unmapped offset holds nothing; foreign address ignored
      host.write_reg(DEVICE_ADDR_DEFAULT, 8'h3a, 8'hff, ack);
      rd(8'h3a, UNMAPPED_READ_VALUE);
      host.write_reg(DEVICE_ADDR_DEFAULT ^ 7'h01, ADDRS[3], ~w[3], ack);
      check({7'h00, ack}, 8'h00);
      rd(ADDRS[3], w[3] & LEVEL_MASK);
      // three-step ramp at each speed, timed from the target change
      for (int s = 0; s < 2; s++) begin
         host.write_reg(DEVICE_ADDR_DEFAULT, ADDR_BUCK2_CONFIG, {1'b0, s[0], 6'h00}, ack);
         target <= target ^ 5'h03;
         lo = 3 * int'(s[0] ? RAMP_SLOW_CYCLES : RAMP_FAST_CYCLES);
         n = 0;
         seen = 1'b0;
         @(posedge sys_clk);
         while (ramped !== target && n < 2000) begin
            @(posedge sys_clk);
            seen = seen | (ramping === 1'b1);
            n++;
         end
         check({6'h00, seen, n >= lo - 2 && n <= lo + 3}, 8'h03);
      end
      summarize();
   end
endmodule : test_buck_regulator_control_registers
`default_nettype wire
